// [rtl/xfer_pkg.sv]
package xfer_pkg;

  // structure of the controller
  localparam int NUM_HALF = 4;
  localparam int NUM_PAIR = 2;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 16;
  localparam int IO_W = 8;
  localparam int DATA_W = 16;

  // upper address bits forced on the short i/o side
  localparam logic [ADDR_W-IO_W-1:0] IO_PAGE = 16'hffff;

  // address steps per unit
  localparam int STEP_BYTE = 1;
  localparam int STEP_WORD = 2;

  // counter value that marks the last unit
  localparam int LAST_COUNT = 1;

  // short address modes
  typedef enum logic [1:0] {
    MODE_IO = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_REPEAT = 2'b10
  } short_mode_t;

  // full address modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_BLOCK = 2'b01
  } full_mode_t;

  // activation sources
  typedef enum logic [2:0] {
    SRC_TMR0 = 3'b000,
    SRC_TMR1 = 3'b001,
    SRC_TMR2 = 3'b010,
    SRC_SER_TX = 3'b011,
    SRC_SER_RX = 3'b100,
    SRC_CONV = 3'b101,
    SRC_EXT = 3'b110,
    SRC_AUTO = 3'b111
  } src_sel_t;

  // transfer sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GRANT = 2'b01,
    ST_READ = 2'b10,
    ST_WRITE = 2'b11
  } xfer_state_t;

endpackage

// [rtl/req_sync.sv]
`timescale 1ns/1ps

module req_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] IDLE_LEVEL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous pins and their synchronised copy
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // two stages; only the second stage is read outside
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= IDLE_LEVEL;
      dout <= IDLE_LEVEL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // req_sync

// [rtl/addr_count.sv]
`timescale 1ns/1ps

module addr_count #(
  parameter int ADDR_W = xfer_pkg::ADDR_W,
  parameter int CNT_W = xfer_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // loading of the initial context
  input wire logic load,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [CNT_W-1:0] load_count,
  // stepping controls
  input wire logic addr_step,
  input wire logic addr_dec,
  input wire logic unit_word,
  input wire logic addr_restore,
  input wire logic count_step,
  input wire logic count_split,
  // current context
  output logic [ADDR_W-1:0] addr,
  output logic [CNT_W-1:0] count,
  output logic count_last
);

  localparam int HALF_W = CNT_W / 2;

  logic [ADDR_W-1:0] init_addr;
  logic [ADDR_W-1:0] delta;
  logic [HALF_W-1:0] upper;
  logic [HALF_W-1:0] reload;

  assign upper = count[CNT_W-1:HALF_W];
  assign reload = count[HALF_W-1:0];
  assign delta = unit_word ? ADDR_W'(xfer_pkg::STEP_WORD) : ADDR_W'(xfer_pkg::STEP_BYTE);
  // a count of zero stands for the full range, so the last unit is at one
  assign count_last = count_split ? (upper == HALF_W'(xfer_pkg::LAST_COUNT))
                                  : (count == CNT_W'(xfer_pkg::LAST_COUNT));

  // address: restart beats stepping so a wrap lands on the initial value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr <= '0;
      init_addr <= '0;
    end else if (load) begin
      addr <= load_addr;
      init_addr <= load_addr;
    end else if (addr_restore) begin
      addr <= init_addr;
    end else if (addr_step) begin
      addr <= addr_dec ? addr - delta : addr + delta;
    end
  end

  // count: split form keeps the initial value in the low byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (load) begin
      count <= load_count;
    end else if (count_step) begin
      if (!count_split) begin
        count <= count - CNT_W'(xfer_pkg::LAST_COUNT);
      end else if (count_last) begin
        count <= {reload, reload};
      end else begin
        count <= {upper - HALF_W'(xfer_pkg::LAST_COUNT), reload};
      end
    end
  end

endmodule // addr_count

// [rtl/transfer_controller.sv]
`timescale 1ns/1ps

module transfer_controller #(
  parameter int NUM_HALF = xfer_pkg::NUM_HALF,
  parameter int NUM_PAIR = xfer_pkg::NUM_PAIR
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // module standby
  input wire logic module_stop,
  // pair configuration
  input wire logic [NUM_PAIR-1:0] pair_mode_sel_hi,
  input wire logic [NUM_PAIR-1:0] pair_mode_sel_lo,
  input wire logic [NUM_PAIR-1:0] pair_burst,
  // half channel configuration, order 0A 0B 1A 1B
  input wire logic [NUM_HALF-1:0] chan_start,
  input wire logic [NUM_HALF-1:0][xfer_pkg::ADDR_W-1:0] mem_addr_init,
  input wire logic [NUM_HALF-1:0][xfer_pkg::IO_W-1:0] io_side_address,
  input wire logic [NUM_HALF-1:0][xfer_pkg::IO_W-1:0] count_upper_byte,
  input wire logic [NUM_HALF-1:0][xfer_pkg::IO_W-1:0] count_reload_byte,
  input wire logic [NUM_HALF-1:0][1:0] chan_mode,
  input wire logic [NUM_HALF-1:0][2:0] chan_source,
  input wire logic [NUM_HALF-1:0] chan_word,
  input wire logic [NUM_HALF-1:0] chan_addr_dec,
  input wire logic [NUM_HALF-1:0] chan_addr_hold,
  // activation sources
  input wire logic [2:0] timer_match_a,
  input wire logic serial_tx_empty,
  input wire logic serial_rx_full,
  input wire logic conv_end,
  input wire logic [NUM_PAIR-1:0] xfer_request_pin_n,
  // bus master side
  output logic bus_req,
  input wire logic bus_grant,
  output logic [xfer_pkg::ADDR_W-1:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic bus_word,
  output logic [xfer_pkg::DATA_W-1:0] bus_wdata,
  input wire logic [xfer_pkg::DATA_W-1:0] bus_rdata,
  input wire logic bus_done,
  // status
  output logic [NUM_PAIR-1:0] xfer_done_pin_n,
  output logic [NUM_HALF-1:0] done_event,
  output logic [NUM_HALF-1:0] chan_busy
);

  localparam int HALF_IW = $clog2(NUM_HALF);
  localparam int AW = xfer_pkg::ADDR_W;

  xfer_pkg::xfer_state_t state;
  logic [HALF_IW-1:0] cur, cur_a, cur_b, pick;
  logic [NUM_PAIR-1:0] full, ext_sync, ext_prev, ext_evt;
  logic [NUM_HALF-1:0] pend, live, src_hit, src_ok, dir_in;
  logic [NUM_HALF-1:0] ctx_addr_step, ctx_count_step, ctx_restore, ctx_split, ctx_last;
  logic [NUM_HALF-1:0][AW-1:0] ctx_addr;
  logic [NUM_HALF-1:0][xfer_pkg::CNT_W-1:0] ctx_count;
  logic any_pick, cur_full, cur_block, cur_repeat, cur_auto;
  logic block_end, last_unit, keep_bus, unit_fin;
  logic [AW-1:0] io_full, src_addr, dst_addr;

  // pair split decode
  assign full = pair_mode_sel_hi & pair_mode_sel_lo;

  // request pins are asynchronous, two stages before any use
  req_sync #(.W(NUM_PAIR)) u_req_sync (
    .clk(clk),
    .nrst(nrst),
    .din(xfer_request_pin_n),
    .dout(ext_sync)
  );

  // falling edge of the synchronised pin is one request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_prev <= '1;
    end else begin
      ext_prev <= ext_sync;
    end
  end
  assign ext_evt = ext_prev & ~ext_sync;

  // per half: event of the selected source, legality, direction
  always_comb begin
    for (int c = 0; c < NUM_HALF; c++) begin
      live[c] = ~full[c / 2] | (c % 2 == 0);
      case (chan_source[c])
        xfer_pkg::SRC_TMR0, xfer_pkg::SRC_TMR1, xfer_pkg::SRC_TMR2: src_hit[c] = timer_match_a[chan_source[c][1:0]];
        xfer_pkg::SRC_SER_TX: src_hit[c] = serial_tx_empty;
        xfer_pkg::SRC_SER_RX: src_hit[c] = serial_rx_full;
        xfer_pkg::SRC_CONV: src_hit[c] = conv_end;
        xfer_pkg::SRC_EXT: src_hit[c] = ext_evt[c / 2];
        xfer_pkg::SRC_AUTO: src_hit[c] = 1'b1;
        default: src_hit[c] = 1'b0;
      endcase
      if (!full[c / 2]) begin
        src_ok[c] = (chan_source[c] != xfer_pkg::SRC_AUTO)
                    && !((chan_source[c] == xfer_pkg::SRC_EXT) && (c % 2 == 0));
      end else if (chan_mode[c] == xfer_pkg::MODE_BLOCK) begin
        src_ok[c] = (chan_source[c] <= xfer_pkg::SRC_TMR2) || (chan_source[c] == xfer_pkg::SRC_EXT)
                    || (chan_source[c] == xfer_pkg::SRC_CONV);
      end else begin
        src_ok[c] = (chan_source[c] == xfer_pkg::SRC_AUTO) || (chan_source[c] == xfer_pkg::SRC_EXT);
      end
      dir_in[c] = (chan_source[c] == xfer_pkg::SRC_SER_RX) || (chan_source[c] == xfer_pkg::SRC_CONV);
    end
  end

  // current channel decode
  assign cur_a = {cur[HALF_IW-1:1], 1'b0};
  assign cur_b = {cur[HALF_IW-1:1], 1'b1};
  assign cur_full = full[cur[HALF_IW-1:1]];
  assign cur_block = cur_full && (chan_mode[cur_a] == xfer_pkg::MODE_BLOCK);
  assign cur_repeat = !cur_full && (chan_mode[cur] == xfer_pkg::MODE_REPEAT);
  assign cur_auto = chan_source[cur_a] == xfer_pkg::SRC_AUTO;
  assign unit_fin = (state == xfer_pkg::ST_WRITE) && bus_done;
  assign block_end = cur_block && ctx_last[cur_b];
  // repeat mode never ends by itself
  assign last_unit = cur_full ? (cur_block ? block_end && ctx_last[cur_a] : ctx_last[cur_a])
                              : (!cur_repeat && ctx_last[cur]);
  // a block, or an auto burst, holds the bus from unit to unit
  assign keep_bus = !last_unit && ((cur_block && !block_end)
                    || (cur_full && !cur_block && cur_auto && pair_burst[cur[HALF_IW-1:1]]));

  // i/o side sits in the top page and is never stepped
  assign io_full = {xfer_pkg::IO_PAGE, io_side_address[cur]};

  // source and destination of the current unit
  always_comb begin
    if (cur_full) begin
      src_addr = ctx_addr[cur_a];
      dst_addr = ctx_addr[cur_b];
    end else if (dir_in[cur]) begin
      src_addr = io_full;
      dst_addr = ctx_addr[cur];
    end else begin
      src_addr = ctx_addr[cur];
      dst_addr = io_full;
    end
  end

  // context stepping; in full mode the B context is destination and block size
  always_comb begin
    for (int k = 0; k < NUM_HALF; k++) begin
      ctx_addr_step[k] = 1'b0;
      ctx_count_step[k] = 1'b0;
      ctx_restore[k] = 1'b0;
      ctx_split[k] = full[k / 2] ? (k % 2 == 1) : (chan_mode[k] == xfer_pkg::MODE_REPEAT);
    end
    if (cur_full) begin
      ctx_addr_step[cur_a] = unit_fin && (cur_block || !chan_addr_hold[cur_a]);
      ctx_addr_step[cur_b] = unit_fin && (cur_block || !chan_addr_hold[cur_b]);
      ctx_restore[cur_a] = unit_fin && block_end && chan_addr_hold[cur_a];
      ctx_restore[cur_b] = unit_fin && block_end && chan_addr_hold[cur_b];
      ctx_count_step[cur_a] = unit_fin && (!cur_block || block_end);
      ctx_count_step[cur_b] = unit_fin && cur_block;
    end else begin
      ctx_addr_step[cur] = unit_fin && (chan_mode[cur] != xfer_pkg::MODE_IDLE);
      ctx_count_step[cur] = unit_fin;
      ctx_restore[cur] = unit_fin && cur_repeat && ctx_last[cur];
    end
  end

  // one address and count context per half channel
  genvar g;
  generate
    for (g = 0; g < NUM_HALF; g++) begin : g_ctx
      addr_count #(.ADDR_W(AW), .CNT_W(xfer_pkg::CNT_W)) u_ctx (
        .clk(clk),
        .nrst(nrst),
        .load(chan_start[g]),
        .load_addr(mem_addr_init[g]),
        .load_count({count_upper_byte[g], count_reload_byte[g]}),
        .addr_step(ctx_addr_step[g]),
        .addr_dec(chan_addr_dec[g]),
        .unit_word(chan_word[g]),
        .addr_restore(ctx_restore[g]),
        .count_step(ctx_count_step[g]),
        .count_split(ctx_split[g]),
        .addr(ctx_addr[g]),
        .count(ctx_count[g]),
        .count_last(ctx_last[g])
      );
    end
  endgenerate

  // channel run state; standby waits for the bus to go quiet first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_busy <= '0;
    end else begin
      for (int c = 0; c < NUM_HALF; c++) begin
        if (module_stop && (state == xfer_pkg::ST_IDLE)) begin
          chan_busy[c] <= 1'b0;
        end else if (chan_start[c]) begin
          chan_busy[c] <= 1'b1;
        end else if (unit_fin && last_unit && ((cur == HALF_IW'(c)) || (cur_full && (cur_b == HALF_IW'(c))))) begin
          chan_busy[c] <= 1'b0; // a full pair frees its B half too
        end
      end
    end
  end

  // pending requests; a new request in the clearing cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= '0;
    end else begin
      for (int c = 0; c < NUM_HALF; c++) begin
        if (!chan_busy[c] || module_stop) begin
          pend[c] <= 1'b0;
        end else if (src_hit[c] && src_ok[c]) begin
          pend[c] <= 1'b1;
        end else if (unit_fin && (cur == HALF_IW'(c)) && (!cur_block || block_end)) begin
          pend[c] <= 1'b0;
        end
      end
    end
  end

  // fixed priority: scanning downwards leaves the lowest index
  always_comb begin
    pick = '0;
    any_pick = 1'b0;
    for (int c = NUM_HALF - 1; c >= 0; c--) begin
      if (pend[c] && chan_busy[c] && live[c]) begin
        pick = HALF_IW'(c);
        any_pick = 1'b1;
      end
    end
  end

  // unit sequencer: request is held from read through write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= xfer_pkg::ST_IDLE;
      cur <= '0;
      bus_req <= 1'b0;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      bus_addr <= '0;
      bus_word <= 1'b0;
      bus_wdata <= '0;
    end else begin
      case (state)
        xfer_pkg::ST_IDLE: begin
          if (any_pick && !module_stop) begin
            bus_req <= 1'b1;
            cur <= pick;
            state <= xfer_pkg::ST_GRANT;
          end
        end
        xfer_pkg::ST_GRANT: begin
          if (bus_grant) begin
            bus_rd <= 1'b1;
            bus_addr <= src_addr;
            bus_word <= chan_word[cur];
            state <= xfer_pkg::ST_READ;
          end
        end
        xfer_pkg::ST_READ: begin
          if (bus_done) begin
            bus_rd <= 1'b0;
            bus_wr <= 1'b1;
            bus_addr <= dst_addr;
            bus_wdata <= bus_rdata;
            state <= xfer_pkg::ST_WRITE;
          end
        end
        xfer_pkg::ST_WRITE: begin
          if (bus_done) begin
            bus_wr <= 1'b0;
            if (keep_bus) begin
              state <= xfer_pkg::ST_GRANT;
            end else begin
              bus_req <= 1'b0;
              state <= xfer_pkg::ST_IDLE;
            end
          end
        end
        default: state <= xfer_pkg::ST_IDLE;
      endcase
    end
  end

  // transfer-end pin low across the last unit's read and write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xfer_done_pin_n <= '1;
    end else if ((state == xfer_pkg::ST_GRANT) && bus_grant && last_unit) begin
      xfer_done_pin_n[cur[HALF_IW-1:1]] <= 1'b0;
    end else if (unit_fin) begin
      xfer_done_pin_n[cur[HALF_IW-1:1]] <= 1'b1;
    end
  end

  // completion event, one pulse per finished run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_event <= '0;
    end else begin
      for (int c = 0; c < NUM_HALF; c++) begin
        done_event[c] <= unit_fin && last_unit && (cur == HALF_IW'(c));
      end
    end
  end

endmodule // transfer_controller

// [bench/transfer_controller_props.sv]
`timescale 1ns/1ps

module transfer_controller_props #(
  parameter int NUM_HALF = 4,
  parameter int NUM_PAIR = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic module_stop,
  // bus side
  input wire logic bus_req,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_done,
  input wire logic [xfer_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [xfer_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [xfer_pkg::DATA_W-1:0] bus_wdata,
  // status
  input wire logic [NUM_PAIR-1:0] xfer_done_pin_n,
  input wire logic [NUM_HALF-1:0] done_event,
  input wire logic [NUM_HALF-1:0] chan_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // one unit is a read then a write, bus kept throughout
  property p_rd_wr_excl; !(bus_rd && bus_wr); endproperty
  a_rd_wr_excl: assert property (p_rd_wr_excl) else $error("read and write strobes together");
  property p_rd_then_wr; bus_rd && bus_done |=> bus_wr && !bus_rd; endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("write did not follow read");
  property p_req_held; (bus_rd || bus_wr) |-> bus_req; endproperty
  a_req_held: assert property (p_req_held) else $error("bus dropped inside a unit");
  property p_rd_hold; bus_rd && !bus_done |=> bus_rd && $stable(bus_addr); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read changed before done");
  property p_wdata; $rose(bus_wr) |-> bus_wdata == $past(bus_rdata); endproperty
  a_wdata: assert property (p_wdata) else $error("write data is not the read data");
  // completion reporting
  property p_event_idle; done_event != '0 |-> (done_event & chan_busy) == '0; endproperty
  a_event_idle: assert property (p_event_idle) else $error("finished half still busy");
  property p_pin_low; xfer_done_pin_n != '1 |-> bus_req; endproperty
  a_pin_low: assert property (p_pin_low) else $error("transfer end low outside a unit");
  property p_event_after_wr; done_event != '0 |-> $past(bus_wr && bus_done); endproperty
  a_event_after_wr: assert property (p_event_after_wr) else $error("event without final write");
  property p_pin_before_event; done_event != '0 |-> $past(xfer_done_pin_n) != '1; endproperty
  a_pin_before_event: assert property (p_pin_before_event) else $error("no transfer end before completion");
  // standby starts nothing new
  property p_standby; module_stop [*2] ##0 !bus_req |=> !bus_req; endproperty
  a_standby: assert property (p_standby) else $error("bus requested in standby");

  c_unit: cover property (bus_rd && bus_done ##1 bus_wr);
  c_event: cover property (done_event != '0);
  c_pin: cover property (xfer_done_pin_n != '1);
endmodule // transfer_controller_props

bind transfer_controller transfer_controller_props #(.NUM_HALF(NUM_HALF), .NUM_PAIR(NUM_PAIR))
  transfer_controller_props_inst (.clk(clk), .nrst(nrst), .module_stop(module_stop), .bus_req(bus_req),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_done(bus_done), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
  .bus_wdata(bus_wdata), .xfer_done_pin_n(xfer_done_pin_n), .done_event(done_event), .chan_busy(chan_busy));

// [bench/bus_partner.sv]
`timescale 1ns/1ps

module bus_partner (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // master side
  input wire logic bus_req,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [23:0] bus_addr,
  input wire logic [3:0] lat,
  output logic bus_grant,
  output logic bus_done,
  output logic [15:0] bus_rdata
);
  logic [3:0] wait_cnt;

  // grant follows request, never pulled between read and write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bus_grant <= 1'b0;
    else bus_grant <= bus_req;
  end

  // one single-cycle done pulse per access after lat wait states; slow runs delay it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_done <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (bus_done) bus_done <= 1'b0;
    else if ((bus_rd || bus_wr) && wait_cnt == lat) begin
      bus_done <= 1'b1;
      wait_cnt <= 4'h0;
    end else if (bus_rd || bus_wr) wait_cnt <= wait_cnt + 4'h1;
  end

  // data valid only during a read; a toggling pattern otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bus_rdata <= 16'h0000;
    else if (bus_rd) bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
    else bus_rdata <= ~bus_rdata;
  end
endmodule // bus_partner

// [bench/transfer_controller_tb.sv]
`timescale 1ns/1ps

module transfer_controller_tb;
  // stimulus
  logic clk = 1'b0, nrst = 1'b0, module_stop = 1'b0;
  logic [1:0] pair_mode_sel_hi = '0, pair_mode_sel_lo = '0, pair_burst = '0, xfer_request_pin_n = 2'h3;
  logic [3:0] chan_start = '0, chan_word = '0, chan_addr_dec = '0, chan_addr_hold = '0, lat = 4'h0;
  logic [3:0][23:0] mem_addr_init = '0;
  logic [3:0][7:0] io_side_address = '0, count_upper_byte = '0, count_reload_byte = '0;
  logic [3:0][1:0] chan_mode = '0;
  logic [3:0][2:0] chan_source = '0;
  logic [2:0] timer_match_a = '0;
  logic serial_tx_empty = 1'b0, serial_rx_full = 1'b0, conv_end = 1'b0;
  // observed
  logic bus_req, bus_grant, bus_rd, bus_wr, bus_word, bus_done;
  logic [23:0] bus_addr, s, d;
  logic [15:0] bus_wdata, bus_rdata;
  logic [1:0] xfer_done_pin_n;
  logic [3:0] done_event, chan_busy;
  // scoreboard
  logic [40:0] q[$];
  logic [40:0] e;
  logic ew = 1'b0;
  int mismatches = 0, comparisons = 0, nwr = 0, n0 = 0;
  int evc[4] = '{0, 0, 0, 0};

  transfer_controller transfer_controller_inst (.clk, .nrst, .module_stop, .pair_mode_sel_hi,
    .pair_mode_sel_lo, .pair_burst, .chan_start, .mem_addr_init, .io_side_address, .count_upper_byte,
    .count_reload_byte, .chan_mode, .chan_source, .chan_word, .chan_addr_dec, .chan_addr_hold,
    .timer_match_a, .serial_tx_empty, .serial_rx_full, .conv_end, .xfer_request_pin_n, .bus_req,
    .bus_grant, .bus_addr, .bus_rd, .bus_wr, .bus_word, .bus_wdata, .bus_rdata, .bus_done,
    .xfer_done_pin_n, .done_event, .chan_busy);
  bus_partner bus_partner_inst (.clk, .nrst, .bus_req, .bus_rd, .bus_wr, .bus_addr, .lat, .bus_grant,
    .bus_done, .bus_rdata);

  always #5 clk = ~clk;

  task automatic chk(input logic [40:0] seen, input logic [40:0] expv);
    comparisons++;
    if (seen !== expv) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // read data the memory model returns for an address
  function automatic logic [15:0] rv(input logic [23:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction

  task automatic exp(input logic [23:0] a, input logic [15:0] v);
    q.push_back({ew, a, v}); // unit size noted with each write
  endtask

  // load a half's context and pulse its start
  task automatic go(input int h, input logic [1:0] m, input logic [2:0] src, input logic w,
                    input logic [23:0] a, input logic [7:0] io, input logic [15:0] cnt);
    @(posedge clk);
    chan_mode[h] <= m;
    chan_source[h] <= src;
    chan_word[h] <= w;
    mem_addr_init[h] <= a;
    io_side_address[h] <= io;
    {count_upper_byte[h], count_reload_byte[h]} <= cnt;
    chan_start[h] <= 1'b1;
    ew = w;
    @(posedge clk);
    chan_start <= '0;
  endtask

  // one-cycle activation pulse
  task automatic ev(input int src);
    @(posedge clk);
    if (src < 3) timer_match_a <= 3'b001 << src;
    serial_tx_empty <= (src == 3);
    serial_rx_full <= (src == 4);
    conv_end <= (src == 5);
    @(posedge clk);
    {timer_match_a, serial_tx_empty, serial_rx_full, conv_end} <= '0;
  endtask

  // falling edge on request pin 0, held long enough for the synchronisers
  task automatic pin();
    @(posedge clk);
    xfer_request_pin_n[0] <= 1'b0;
    repeat (6) @(posedge clk);
    xfer_request_pin_n[0] <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // bounded wait until every expected write is seen and the bus is free
  task automatic drain();
    for (int i = 0; i < 500; i++) begin
      @(posedge clk);
      if (q.size() == 0 && bus_req !== 1'b1) begin
        @(posedge clk); // let the monitor count this edge's event first
        return;
      end
    end
    chk(40'h1, 40'h0);
    wrap_up();
  endtask

  // monitor: each finished write is matched against the oldest note
  always @(posedge clk) begin
    if (nrst) begin
      for (int i = 0; i < 4; i++) if (done_event[i] === 1'b1) evc[i]++;
      if (bus_wr === 1'b1 && bus_done === 1'b1) begin
        nwr++;
        e = (q.size() > 0) ? q.pop_front() : 41'hx;
        chk({bus_word, bus_addr, bus_wdata}, e);
      end
    end
  end

  initial begin
    void'($urandom(32'h5a06));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // short i/o, every memory-to-i/o source
    for (int j = 0; j < 4; j++) begin
      s = $urandom & 24'hfffffe;
      go(0, 2'b00, j[2:0], 1'b0, s, 8'h40, 16'h0001);
      exp({16'hffff, 8'h40}, rv(s));
      ev(j);
      drain();
      chk(chan_busy[0], 1'b0);
    end
    chk(evc[0], 4);
    $display("test short io done");
    // idle mode, i/o-to-memory sources, address held even with decrement set
    chan_addr_dec[1] <= 1'b1;
    for (int j = 4; j < 6; j++) begin
      d = $urandom & 24'hfffffe;
      go(1, 2'b01, j[2:0], 1'b1, d, 8'h80, 16'h0002);
      repeat (2) begin
        exp(d, rv({16'hffff, 8'h80}));
        ev(j);
        drain();
      end
    end
    $display("test idle done");
    // external pin refused on the A half, taken on the B half
    n0 = nwr;
    go(0, 2'b00, 3'd6, 1'b0, s, 8'h44, 16'h0001);
    pin();
    repeat (20) @(posedge clk);
    chk(nwr, n0);
    go(1, 2'b00, 3'd6, 1'b0, s, 8'h44, 16'h0001);
    exp({16'hffff, 8'h44}, rv(s));
    pin();
    drain();
    $display("test request pin done");
    // repeat mode wraps address, then standby stops everything
    chan_addr_dec[2] <= 1'b1;
    s = $urandom & 24'hfffffe;
    go(2, 2'b10, 3'd1, 1'b0, s, 8'h60, 16'h0202);
    for (int k = 0; k < 3; k++) begin
      exp({16'hffff, 8'h60}, rv(k == 1 ? s - 24'h1 : s));
      ev(1);
      drain();
    end
    chk(chan_busy[2], 1'b1);
    module_stop <= 1'b1;
    repeat (6) @(posedge clk);
    chk(chan_busy, 4'h0);
    module_stop <= 1'b0;
    $display("test repeat done");
    // full normal auto-request, burst then cycle steal with a slow bus
    {pair_mode_sel_hi[1], pair_mode_sel_lo[1], chan_addr_dec[2]} <= 3'b110;
    for (int b = 1; b >= 0; b--) begin
      pair_burst[1] <= b[0];
      lat <= b[0] ? 4'h0 : 4'h3;
      s = $urandom & 24'hfffffe;
      d = $urandom & 24'hfffffe;
      go(3, 2'b00, 3'd7, 1'b1, d, 8'h00, 16'h0003);
      for (int k = 0; k < 3; k++) exp(d + 24'(2 * k), rv(s + 24'(2 * k)));
      go(2, 2'b00, 3'd7, 1'b1, s, 8'h00, 16'h0003);
      drain();
    end
    chk(evc[2] + evc[3], 2);
    $display("test full normal done");
    // block mode, fixed destination area restarting each block
    {pair_mode_sel_hi[0], pair_mode_sel_lo[0], lat} <= 6'h30;
    chan_addr_hold <= 4'b0010;
    chan_addr_dec <= '0;
    s = $urandom & 24'hfffffe;
    d = $urandom & 24'hfffffe;
    go(1, 2'b00, 3'd7, 1'b0, d, 8'h00, 16'h0202);
    go(0, 2'b01, 3'd2, 1'b0, s, 8'h00, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      for (int u = 0; u < 2; u++) exp(d + 24'(u), rv(s + 24'(2 * k + u)));
      ev(2);
      drain();
    end
    chk(evc[0] + evc[1], 8);
    $display("test block done");
    wrap_up();
  end
endmodule // transfer_controller_tb
